// >>> design/sbh_host.sv
// host end: serial master driving the boot sequence
// assumes pins via sbh_link_if host modport
`timescale 1ns/1ps
`default_nettype none
module sbh_host #(
    parameter int unsigned WAIT_CYC = sbh_pkg::WAIT_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // link
    sbh_link_if.host link,
    // user commands
    input wire logic enter_prog_i,
    input wire logic enter_run_i,
    input wire logic seg_start_i,
    input wire logic seg_read_i,
    input wire logic [31:0] seg_data_i,
    // user results
    output logic [31:0] seg_rx_o,
    output logic seg_done_o,
    output logic ready_o
);
    typedef enum logic [2:0] {H_IDLE, H_RST, H_REL, H_WREADY,
        H_SHIFT, H_WLOW, H_WHIGH} sbh_host_e;
    sbh_host_e state;
    logic hs, run_after;
    logic [31:0] sh;
    logic [5:0] nbits;
    logic [15:0] cnt;
    logic [3:0] div;

    sbh_sync u_hs (.clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(link.handshake_pin), .q_o(hs));

    wire tick = (div == 4'(sbh_pkg::HALF_CYC - 1));

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || state != H_SHIFT || tick) div <= '0;
        else div <= div + 4'h1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= H_IDLE;
            link.select_pin_n <= 1'b1;
            link.serial_clock_pin <= 1'b0;
            link.slave_in_pin <= 1'b0;
            link.boot_select_pin <= 1'b0;
            link.dev_reset <= 1'b0;
            run_after <= 1'b0;
            sh <= '0;
            nbits <= '0;
            cnt <= '0;
            seg_rx_o <= '0;
            seg_done_o <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            seg_done_o <= 1'b0;
            unique case (state)
                H_IDLE: begin
                    ready_o <= hs;
                    if (enter_prog_i || enter_run_i) begin
                        run_after <= enter_run_i;
                        link.boot_select_pin <= enter_prog_i;
                        link.dev_reset <= 1'b1;
                        cnt <= 16'(WAIT_CYC);
                        ready_o <= 1'b0;
                        state <= H_RST;
                    end else if (seg_start_i && hs) begin
                        ready_o <= 1'b0;
                        link.select_pin_n <= 1'b0;
                        // first bit set up with select, before first rise
                        link.slave_in_pin <= !seg_read_i &
                            seg_data_i[31];
                        sh <= seg_read_i ? '0 : seg_data_i;
                        run_after <= seg_read_i;
                        nbits <= '0;
                        state <= H_SHIFT;
                    end
                end
                H_RST: if (cnt != '0) cnt <= cnt - 16'h1;
                else begin
                    link.dev_reset <= 1'b0;
                    cnt <= 16'(WAIT_CYC);
                    state <= H_REL;
                end
                H_REL: if (cnt != '0) cnt <= cnt - 16'h1;
                else begin
                    link.boot_select_pin <= 1'b0;
                    state <= run_after ? H_IDLE : H_WREADY;
                end
                H_WREADY: if (hs) state <= H_IDLE;
                H_SHIFT: if (tick) begin
                    if (!link.serial_clock_pin) begin
                        if (nbits == 6'(sbh_pkg::SEG_BITS)) begin
                            link.select_pin_n <= 1'b1;
                            link.slave_in_pin <= 1'b0;
                            seg_rx_o <= sh;
                            state <= H_WLOW;
                        end else begin
                            link.serial_clock_pin <= 1'b1;
                        end
                    end else begin
                        link.serial_clock_pin <= 1'b0;
                        nbits <= nbits + 6'h1;
                        if (run_after) begin
                            sh <= {sh[30:0], link.slave_out_pin};
                        end else begin
                            sh <= {sh[30:0], 1'b0};
                            link.slave_in_pin <= sh[30];
                        end
                    end
                end
                H_WLOW: if (!hs) state <= H_WHIGH;
                H_WHIGH: if (hs) begin
                    seg_done_o <= 1'b1;
                    ready_o <= 1'b1;
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> shared/sbh_pkg.sv
// constants shared by both ends of the boot handshake serial link
// assumes a 10 MHz reference clock on both ends
//
// Operation
// - device slave drives only slave out
// - select active low frames transfer
// - half duplex: one data line per transfer
// - bytes shifted most significant bit first
// - host keeps serial clock low idle
// - device samples rising, changes out rising
// - host changes and samples on falling
// - serial clock at most 2 MHz
// - handshake low busy, high ready
// - host waits handshake high before command
// - boot select at reset release picks mode
// - host entry sequence with 1 ms waits
// - handshake low until programming mode ready
// - segments four bytes, messages two or more
// - host selects only when handshake high
// - device pulses handshake after each segment
// - host waits low-high pulse between segments
// - device shifts response segment on slave out
// - busy 30 us to 60 ms, host samples; device enforces only the 30 us floor, busy_cyc_i has no 60 ms cap
// - first segment starts with header bytes
// - host restarts device in runtime mode
// - error gives unexpected response, host restarts
package sbh_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SCLK_MAX_HZ = 2_000_000;
    localparam int unsigned WAIT_MS = 1;
    localparam int unsigned WAIT_CYC = CLK_HZ / 1000 * WAIT_MS;
    localparam int unsigned BUSY_MIN_US = 30;
    localparam int unsigned BUSY_MIN_CYC = (CLK_HZ / 1_000_000) * BUSY_MIN_US;
    // half period of generated clock, rounded up for the ceiling rate
    localparam int unsigned HALF_CYC =
        (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int unsigned SEG_BYTES = 4;
    localparam int unsigned SEG_BITS = SEG_BYTES * 8;
    localparam logic [7:0] HDR0 = 8'ha5;
    localparam logic [7:0] HDR1 = 8'h5a;
    localparam logic [7:0] HDR2 = 8'ha5;
    localparam logic [7:0] OP_EXAMPLE = 8'h4b;
endpackage

// >>> shared/sbh_link_if.sv
// pins between host and device of the boot handshake link
// assumes the bench resolves nothing: all pins are one-way
`timescale 1ns/1ps
`default_nettype none
interface sbh_link_if;
    logic select_pin_n;
    logic serial_clock_pin;
    logic slave_in_pin;
    logic slave_out_pin;
    logic handshake_pin;
    logic boot_select_pin;
    logic dev_reset;
    modport dev (
        input select_pin_n, serial_clock_pin, slave_in_pin,
        input boot_select_pin, dev_reset,
        output slave_out_pin, handshake_pin
    );
    modport host (
        output select_pin_n, serial_clock_pin, slave_in_pin,
        output boot_select_pin, dev_reset,
        input slave_out_pin, handshake_pin
    );
endinterface
`default_nettype wire

// >>> design/sbh_sync.sv
// three stage synchroniser with agreement filter
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module sbh_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // async level in, filtered level out
    input wire logic d_i,
    output logic q_o
);
    logic s1, s2, s3;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // change accepted once second and third agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else if (s2 == s3) begin
            q_o <= s3;
        end
    end
endmodule
`default_nettype wire

// >>> design/sbh_device.sv
// device end: serial slave with busy handshake
// assumes pins arrive via sbh_link_if dev modport
`timescale 1ns/1ps
`default_nettype none
module sbh_device (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // link
    sbh_link_if.dev link,
    // user side: received segment
    output logic [31:0] rx_seg_o,
    output logic rx_valid_o,
    // user side: segment to send, busy time
    input wire logic [31:0] tx_seg_i,
    input wire logic tx_mode_i,
    input wire logic [23:0] busy_cyc_i,
    // user side: status
    output logic prog_mode_o,
    output logic ready_o
);
    typedef enum logic [2:0] {ST_CFG, ST_RUN, ST_IDLE, ST_XFER,
        ST_BUSY} sbh_dev_e;
    sbh_dev_e state;
    logic cs_n, sck, sdi, bsel, rst_pin, sck_d, tx_dir;
    logic [31:0] sh;
    logic [5:0] nbits;
    logic [23:0] cnt;
    logic [23:0] busy_len;

    sbh_sync u_cs (.clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(link.select_pin_n), .q_o(cs_n));
    sbh_sync u_ck (.clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(link.serial_clock_pin), .q_o(sck));
    sbh_sync u_di (.clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(link.slave_in_pin), .q_o(sdi));
    sbh_sync u_bs (.clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(link.boot_select_pin), .q_o(bsel));
    sbh_sync u_rs (.clk_i(ref_clk_i), .rst_i(rst_i),
        .d_i(link.dev_reset), .q_o(rst_pin));

    wire rise = sck & ~sck_d;
    assign busy_len = (busy_cyc_i < 24'(sbh_pkg::BUSY_MIN_CYC))
        ? 24'(sbh_pkg::BUSY_MIN_CYC) : busy_cyc_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) sck_d <= 1'b0;
        else sck_d <= sck;
    end

    // ============================================================
    // mode and handshake state
    // ============================================================
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || rst_pin) begin
            state <= ST_CFG;
            prog_mode_o <= 1'b0;
            cnt <= '0;
        end else begin
            unique case (state)
                ST_CFG: begin
                    // strap read on first cycle after reset release
                    prog_mode_o <= bsel;
                    if (bsel) begin
                        cnt <= 24'(sbh_pkg::BUSY_MIN_CYC);
                        state <= ST_BUSY;
                    end else begin
                        // runtime: strap not looked at again
                        state <= ST_RUN;
                    end
                end
                ST_RUN: state <= ST_RUN;
                ST_IDLE: if (!cs_n) state <= ST_XFER;
                ST_XFER: if (cs_n) begin
                    cnt <= busy_len;
                    state <= ST_BUSY;
                end
                ST_BUSY: begin
                    if (cnt != '0) cnt <= cnt - 24'h1;
                    else state <= ST_IDLE;
                end
                default: state <= ST_CFG;
            endcase
        end
    end

    // handshake low in config and busy, high when ready
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || rst_pin) begin
            link.handshake_pin <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            // stays high through the transfer, drops once select rises
            link.handshake_pin <= (state == ST_IDLE) ||
                (state == ST_XFER);
            ready_o <= (state == ST_IDLE) || (state == ST_XFER);
        end
    end

    // ============================================================
    // shifter
    // ============================================================
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sh <= '0;
            nbits <= '0;
            tx_dir <= 1'b0;
            link.slave_out_pin <= 1'b0;
            rx_seg_o <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            if (state == ST_IDLE && !cs_n) begin
                tx_dir <= tx_mode_i;
                nbits <= '0;
                sh <= tx_mode_i ? {tx_seg_i[30:0], 1'b0} : '0;
                link.slave_out_pin <= tx_mode_i & tx_seg_i[31];
            end else if (state == ST_XFER && rise) begin
                if (tx_dir) begin
                    // msb first, changed on rising edge
                    link.slave_out_pin <= sh[31];
                    sh <= {sh[30:0], 1'b0};
                end else begin
                    sh <= {sh[30:0], sdi};
                end
                nbits <= nbits + 6'h1;
            end else if (state == ST_XFER && cs_n) begin
                link.slave_out_pin <= 1'b0;
                // only a full four byte segment is delivered
                if (!tx_dir && nbits == 6'(sbh_pkg::SEG_BITS)) begin
                    rx_seg_o <= sh;
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/sbh_link_properties.sv
// pin-level checks on the boot handshake link
// assumes it sits beside the link interface, 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module sbh_link_properties #(
    parameter int unsigned WAIT_CYC = sbh_pkg::WAIT_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // link pins
    input wire logic select_pin_n,
    input wire logic serial_clock_pin,
    input wire logic slave_in_pin,
    input wire logic handshake_pin,
    input wire logic boot_select_pin,
    input wire logic dev_reset
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [5:0] rise_cnt;
    logic [19:0] low_cnt;
    logic [19:0] rst_cnt;
    logic seg_seen;
    // =========================================
    // helper counters
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || select_pin_n) rise_cnt <= '0;
        else if ($rose(serial_clock_pin)) rise_cnt <= rise_cnt + 6'h01;
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || handshake_pin) low_cnt <= '0;
        else low_cnt <= low_cnt + 20'h00001;
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !dev_reset) rst_cnt <= '0;
        else rst_cnt <= rst_cnt + 20'h00001;
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) seg_seen <= 1'b0;
        else if ($rose(select_pin_n)) seg_seen <= 1'b1;
        else if ($rose(handshake_pin)) seg_seen <= 1'b0;
    end
    // =========================================
    // properties
    property p_idle_clk;
        select_pin_n |-> !serial_clock_pin;
    endproperty
    a_idle_clk: assert property (p_idle_clk)
        else $error("serial clock high while idle");
    property p_sel_ready;
        !select_pin_n |-> handshake_pin;
    endproperty
    a_sel_ready: assert property (p_sel_ready)
        else $error("select low while handshake low");
    property p_pulse;
        $rose(select_pin_n) |-> ##[1:8] !handshake_pin;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("no handshake pulse after segment");
    property p_busy_min;
        $rose(handshake_pin) && seg_seen |-> low_cnt >= sbh_pkg::BUSY_MIN_CYC;
    endproperty
    a_busy_min: assert property (p_busy_min)
        else $error("busy period too short");
    property p_bits;
        $rose(select_pin_n) |-> rise_cnt == 6'h20;
    endproperty
    a_bits: assert property (p_bits)
        else $error("segment not 32 clocks");
    property p_clk_high;
        $rose(serial_clock_pin) |-> serial_clock_pin[*3];
    endproperty
    a_clk_high: assert property (p_clk_high)
        else $error("serial clock high phase too short");
    property p_mosi_fall;
        !select_pin_n && !$fell(select_pin_n) && $changed(slave_in_pin)
            |-> $fell(serial_clock_pin);
    endproperty
    a_mosi_fall: assert property (p_mosi_fall)
        else $error("slave in changed off a falling clock");
    property p_reset_len;
        $fell(dev_reset) |-> rst_cnt >= WAIT_CYC;
    endproperty
    a_reset_len: assert property (p_reset_len)
        else $error("device reset too short");
    property p_config_low;
        dev_reset[*8] |-> !handshake_pin;
    endproperty
    a_config_low: assert property (p_config_low)
        else $error("handshake high during config");
    property p_run_low;
        $fell(dev_reset) && !boot_select_pin |-> !handshake_pin[*8];
    endproperty
    a_run_low: assert property (p_run_low)
        else $error("handshake high in runtime mode");
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench: host and device joined by the link
// assumes shortened reset waits, 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned WAIT = 20;
    logic ref_clk, rst, enter_prog, enter_run, seg_start, seg_read;
    logic tx_mode, seg_done, host_rdy, rx_valid, prog_mode, dev_rdy;
    logic [31:0] seg_data, seg_rx, rx_seg, tx_seg, mosi_sr;
    logic [23:0] busy_cyc;
    int err_total = 0, n_compared = 0, lo_run = 0, last_lo = 0, rx_cnt = 0;
    sbh_link_if link_if();
    sbh_host #(.WAIT_CYC(WAIT)) u_sbh_host (.ref_clk_i(ref_clk),
        .rst_i(rst), .link(link_if), .enter_prog_i(enter_prog),
        .enter_run_i(enter_run), .seg_start_i(seg_start),
        .seg_read_i(seg_read), .seg_data_i(seg_data), .seg_rx_o(seg_rx),
        .seg_done_o(seg_done), .ready_o(host_rdy));
    sbh_device u_sbh_device (.ref_clk_i(ref_clk), .rst_i(rst),
        .link(link_if), .rx_seg_o(rx_seg), .rx_valid_o(rx_valid),
        .tx_seg_i(tx_seg), .tx_mode_i(tx_mode), .busy_cyc_i(busy_cyc),
        .prog_mode_o(prog_mode), .ready_o(dev_rdy));
    sbh_link_properties #(.WAIT_CYC(WAIT)) u_sbh_link_properties (
        .ref_clk_i(ref_clk), .rst_i(rst),
        .select_pin_n(link_if.select_pin_n),
        .serial_clock_pin(link_if.serial_clock_pin),
        .slave_in_pin(link_if.slave_in_pin),
        .handshake_pin(link_if.handshake_pin),
        .boot_select_pin(link_if.boot_select_pin),
        .dev_reset(link_if.dev_reset));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // =========================================
    // wire monitors
    always @(posedge link_if.serial_clock_pin) begin
        mosi_sr = {mosi_sr[30:0], link_if.slave_in_pin};
    end
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) rx_cnt++;
        if (link_if.handshake_pin === 1'b0) lo_run++;
        else if (lo_run != 0) begin
            last_lo = lo_run;
            lo_run = 0;
        end
    end
    // =========================================
    // tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_rdy;
        int i = 0;
        while (host_rdy !== 1'b1 && i < 20000) begin
            @(negedge ref_clk);
            i++;
        end
        if (host_rdy !== 1'b1) begin
            err_total++;
            test_done();
        end
    endtask
    task automatic seg(input logic rd, input logic [31:0] d,
                       input logic [23:0] b);
        int i = 0;
        busy_cyc = b;
        seg_start = 1'b1;
        seg_read = rd;
        seg_data = d;
        @(negedge ref_clk);
        seg_start = 1'b0;
        while (seg_done !== 1'b1 && i < 5000) begin
            @(negedge ref_clk);
            i++;
        end
        if (seg_done !== 1'b1) begin
            err_total++;
            test_done();
        end
        wait_rdy();
    endtask
    task automatic wr(input logic [31:0] d, input logic [23:0] b);
        int n;
        n = rx_cnt;
        tx_mode = 1'b0;
        seg(1'b0, d, b);
        chk("rx_seg", d, rx_seg);
        chk("mosi_wire", d, mosi_sr);
        chk("rx_count", n + 1, rx_cnt);
        chk("busy_len", (b < 300 ? 300 : b) + 1, last_lo);
    endtask
    task automatic rd(input logic [31:0] d, input logic [23:0] b);
        tx_mode = 1'b1;
        tx_seg = d;
        seg(1'b1, 32'h0000_0000, b);
        chk("seg_rx", d, seg_rx);
        chk("busy_len", (b < 300 ? 300 : b) + 1, last_lo);
    endtask
    task automatic boot(input logic prog);
        enter_prog = prog;
        enter_run = !prog;
        @(negedge ref_clk);
        enter_prog = 1'b0;
        enter_run = 1'b0;
    endtask
    // =========================================
    // main sequence
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        {enter_prog, enter_run, seg_start, seg_read, tx_mode} = 5'h00;
        {seg_data, tx_seg} = 64'h0;
        busy_cyc = 24'h000190;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        boot(1'b1);
        wait_rdy();
        chk("prog_mode", 32'h1, {31'h0, prog_mode});
        chk("dev_ready", 32'h1, {31'h0, dev_rdy});
        wr({sbh_pkg::HDR0, sbh_pkg::HDR1, sbh_pkg::HDR2,
            sbh_pkg::OP_EXAMPLE}, 24'h000190);
        wr(32'h0000_00f0, 24'h00000a);
        rd(32'ha55a_a58c, 24'h00012c);
        rd(32'h0401_0036, 24'h000191);
        boot(1'b0);
        repeat (2 * WAIT + 60) @(negedge ref_clk);
        chk("run_mode", 32'h0, {31'h0, prog_mode});
        chk("run_hs", 32'h0, {31'h0, link_if.handshake_pin});
        boot(1'b1);
        wait_rdy();
        chk("reprog", 32'h1, {31'h0, prog_mode});
        wr(32'h8000_0001, 24'h00012c);
        test_done();
    end
endmodule
`default_nettype wire
